// file: pkg/capture_job_pkg.sv
// Purpose: constants and types shared by the capture job control block
// Assumes: 25 MHz reference clock, classic Wishbone register access
// Notes: register offsets are byte addresses of 32-bit words
package capture_job_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TIME_RES_NS = 1000;
  localparam int unsigned US_CYCLES = TIME_RES_NS / (1_000_000_000 / CLK_HZ);
  localparam logic [4:0] US_LAST = 5'(US_CYCLES - 1);
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_CHAN = 8'h08;
  localparam logic [7:0] OFS_OFFSET = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_DEST = 8'h14;
  localparam logic [7:0] OFS_BASE = 8'h18;
  localparam logic [7:0] OFS_CFG = 8'h1C;
  localparam logic [7:0] OFS_RESULT = 8'h20;
  localparam logic [7:0] OFS_STAMP = 8'h24;
  localparam logic [7:0] OFS_TIMER = 8'h28;
  // Job mode codes
  localparam logic [7:0] MODE_START = 8'h01;
  localparam logic [7:0] MODE_READ_MULTI = 8'h00;
  localparam logic [7:0] MODE_READ_ONCE = 8'h80;
  // Result words and fields
  localparam logic [15:0] RES_OK = 16'h0000;
  localparam logic [15:0] RES_NOT_STARTED = 16'h0004;
  localparam logic [15:0] RES_NOT_CONFIGURED = 16'h8002;
  localparam logic [15:0] RES_INTERNAL = 16'h8003;
  localparam logic [15:0] RES_BAD_CHANNEL = 16'h8005;
  localparam logic [15:0] RES_BAD_OFFSET = 16'h8007;
  localparam logic [15:0] RES_NO_MODULE = 16'h8090;
  localparam logic [15:0] RES_ADDR_RANGE = 16'h80D2;
  localparam int unsigned BIT_TRIGGERED = 4;
  localparam int unsigned BIT_WAIT_TRIG = 5;
  localparam logic [3:0] STATE_RUN = 4'h7;
  localparam logic [3:0] STATE_ERR = 4'h8;
  localparam logic [1:0] PH_IDLE = 2'h0;
  localparam logic [1:0] PH_FIRST = 2'h1;
  localparam logic [1:0] PH_NEXT = 2'h2;
  localparam logic [1:0] PH_SCOPE = 2'h3;
  // Configuration fields
  localparam int unsigned CFG_OP_LSB = 0;
  localparam int unsigned CFG_TRIG_LSB = 2;
  localparam int unsigned CFG_CHSEL_LSB = 4;
  localparam int unsigned CFG_TRIGCH_LSB = 8;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_SCOPE = 2'h1;
  localparam logic [1:0] OP_FIFO = 2'h2;
  localparam logic [1:0] TRIG_RISE = 2'h0;
  localparam logic [1:0] TRIG_FALL = 2'h1;
  localparam logic [1:0] TRIG_MANUAL = 2'h2;
  // Sizes and addresses (OWN_BASE value is arbitrary)
  localparam logic [31:0] OWN_BASE = 32'h0000_0100;
  localparam logic [31:0] ADDR_LIMIT = 32'h0000_0FFF;
  localparam logic [16:0] SCOPE_VALUES = 17'h10000;
  localparam logic [16:0] FIFO_DEPTH = 17'h01FFE;
  localparam logic [16:0] READ_CHUNK = 17'h00010;
  typedef enum {REC_OFF, REC_ARMED, REC_RUN, REC_FULL, REC_FIFO} rec_state_t;
  typedef enum {JOB_IDLE, JOB_WAIT, JOB_READ} job_state_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
  } wb_req_t;
  typedef struct packed {
    logic valid;
    logic [2:0] channel;
    logic [16:0] index;
  } xfer_t;
endpackage

// file: verilog/capture_buffer_job_control.sv
// Purpose: job control of the waveform recorder (start, read, result word)
// Assumes: acquisition events arrive on i_ref_clk from local logic
// Notes: sample storage itself lives outside; reads emit index strobes
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
// Operation
// - Job mode selects start, chunked or single read
// - Start arms trigger or records; read transfers data
// - Scope data readable only once buffer full
// - FIFO data readable any time after start
// - Read delivers selected channel; start ignores it
// - Read begins at offset; FIFO ignores offset
// - FIFO read returns all stored; area checked
// - Busy high while job runs, low after
// - Free microsecond timer captured at trigger
// - Timestamp only for edge scope, when valid
// - Start uses count only for manual scope
// - Read count in, values read returned
// - Result low bits report call phase
// - Read before any recording sets bit two
// - Bits four, five: triggered, waiting trigger
// - Byte one flags: area, range, overflow
// - Upper nibble: done, running, error
// - Errors for unconfigured, fault, bad channel
// - Errors for offset, absent module, address
// - FIFO holds 8190 per channel, wraps, flags
// - Config write stops any recording
// - Trigger condition: rise, fall, manual
module capture_buffer_job_control (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Wishbone slave
  input wire capture_job_pkg::wb_req_t i_wb,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Acquisition events
  input wire logic i_sample_tick,
  input wire logic [7:0] i_rise,
  input wire logic [7:0] i_fall,
  input wire logic i_fault,
  // Job outputs
  output logic o_busy,
  output capture_job_pkg::xfer_t o_xfer
);
  import capture_job_pkg::*;

  logic [31:0] cfg, job_mode, chan, offset, count_in, dest_words, base_addr;
  logic [31:0] count_out, timer, stamp;
  logic [15:0] result;
  logic [4:0] us_div;
  rec_state_t rec_state;
  job_state_t job_state;
  logic [16:0] rec_count, capacity, idx, left, grant, done;
  logic [2:0] flags;
  logic fifo_ovf, trig_seen, read_multi;

  logic take, wr, call, req, cfg_write, trig_hit, rec_active;
  logic is_start, is_read, start_go, fifo_take, xfer_go, stamp_valid;
  logic [1:0] op, tcond, chsel;
  logic [2:0] tch;
  logic [16:0] cap_max, remain, len0, rd_len, rd_start, dest17, cnt17;
  logic [15:0] first_err;
  logic [7:0] nch;
  logic [2:0] rd_flags;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic [16:0] clip17(input logic [31:0] v);
    return (v[31:17] != 15'h0) ? 17'h1FFFF : v[16:0];
  endfunction

  assign op = cfg[CFG_OP_LSB +: 2];
  assign tcond = cfg[CFG_TRIG_LSB +: 2];
  assign chsel = cfg[CFG_CHSEL_LSB +: 2];
  assign tch = cfg[CFG_TRIGCH_LSB +: 3];
  assign take = i_wb.cyc & i_wb.stb & ~o_wb_ack;
  assign wr = take & i_wb.we;
  assign call = wr & (i_wb.adr == OFS_CTRL) & i_wb.sel[0];
  assign req = i_wb.dat[0];
  assign cfg_write = wr & (i_wb.adr == OFS_CFG);
  assign rec_active = (rec_state == REC_ARMED) | (rec_state == REC_RUN);
  assign is_start = job_mode[7:0] == MODE_START;
  assign is_read = (job_mode[7:0] == MODE_READ_MULTI) |
                   (job_mode[7:0] == MODE_READ_ONCE);
  assign cap_max = SCOPE_VALUES >> chsel;
  assign nch = 8'h01 << chsel;
  assign dest17 = clip17(dest_words);
  assign cnt17 = clip17(count_in);
  assign trig_hit = (rec_state == REC_ARMED) &
                    ((tcond == TRIG_FALL) ? i_fall[tch] : i_rise[tch]);
  assign xfer_go = (left != 17'h0) & (grant != 17'h0);
  assign stamp_valid = (op == OP_SCOPE) & (tcond != TRIG_MANUAL) &
                       trig_seen &
                       ((rec_state == REC_RUN) | (rec_state == REC_FULL));

  // Checks of a first call, most general fault first
  always_comb begin
    first_err = RES_OK;
    if (base_addr > ADDR_LIMIT) first_err = RES_ADDR_RANGE;
    else if (base_addr != OWN_BASE) first_err = RES_NO_MODULE;
    else if (op == OP_NONE) first_err = RES_NOT_CONFIGURED;
    else if (i_fault) first_err = RES_INTERNAL;
    else if (is_read & ((chan > 32'h7) |
             ((op == OP_SCOPE) & (chan[7:0] >= nch))))
      first_err = RES_BAD_CHANNEL;
    else if (is_read & (op == OP_SCOPE) & (rec_state == REC_FULL) &
             (offset > {15'h0, rec_count}))
      first_err = RES_BAD_OFFSET;
  end

  // Read window: scope honours offset and count, FIFO takes everything
  always_comb begin
    rd_flags = 3'h0;
    if (op == OP_FIFO) begin
      rd_start = 17'h0;
      remain = fifo_ovf ? FIFO_DEPTH : rec_count;
      len0 = remain;
      rd_flags[2] = fifo_ovf;
    end else begin
      rd_start = offset[16:0];
      remain = rec_count - offset[16:0];
      len0 = ((count_in == 32'h0) | (cnt17 > remain)) ? remain : cnt17;
      rd_flags[1] = (count_in != 32'h0) & (cnt17 > remain);
    end
    rd_flags[0] = len0 > dest17;
    rd_len = rd_flags[0] ? dest17 : len0;
  end

  assign start_go = call & req & (job_state == JOB_IDLE) & is_start &
                    (first_err == RES_OK) & ~rec_active;
  assign fifo_take = call & req & (job_state == JOB_IDLE) & is_read &
                     (first_err == RES_OK) & (rec_state == REC_FIFO);

  // Register writes honour byte selects
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cfg <= CFG_RESET;
      job_mode <= 32'h0;
      chan <= 32'h0;
      offset <= 32'h0;
      count_in <= 32'h0;
      dest_words <= 32'h0;
      base_addr <= 32'h0;
    end else if (wr) begin
      case (i_wb.adr)
        OFS_MODE: job_mode <= merge(job_mode, i_wb.dat, i_wb.sel);
        OFS_CHAN: chan <= merge(chan, i_wb.dat, i_wb.sel);
        OFS_OFFSET: offset <= merge(offset, i_wb.dat, i_wb.sel);
        OFS_COUNT: count_in <= merge(count_in, i_wb.dat, i_wb.sel);
        OFS_DEST: dest_words <= merge(dest_words, i_wb.dat, i_wb.sel);
        OFS_BASE: base_addr <= merge(base_addr, i_wb.dat, i_wb.sel);
        OFS_CFG: cfg <= merge(cfg, i_wb.dat, i_wb.sel);
        default: ;
      endcase
    end
  end

  // Reads answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      o_wb_ack <= take;
      if (take & ~i_wb.we) begin
        case (i_wb.adr)
          OFS_CTRL: o_wb_dat <= {31'h0, o_busy};
          OFS_MODE: o_wb_dat <= {24'h0, job_mode[7:0]};
          OFS_CHAN: o_wb_dat <= {24'h0, chan[7:0]};
          OFS_OFFSET: o_wb_dat <= offset;
          OFS_COUNT: o_wb_dat <= count_out;
          OFS_DEST: o_wb_dat <= dest_words;
          OFS_BASE: o_wb_dat <= {16'h0, base_addr[15:0]};
          OFS_CFG: o_wb_dat <= cfg;
          OFS_RESULT: o_wb_dat <= {16'h0, result};
          OFS_STAMP: o_wb_dat <= stamp_valid ? stamp : 32'h0;
          OFS_TIMER: o_wb_dat <= timer;
          default: o_wb_dat <= 32'h0;
        endcase
      end
    end
  end

  // Free-running microsecond time base
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      us_div <= 5'h0;
      timer <= 32'h0;
    end else if (us_div == US_LAST) begin
      us_div <= 5'h0;
      timer <= timer + 32'h1;
    end else begin
      us_div <= us_div + 5'h1;
    end
  end

  // Recording state
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rec_state <= REC_OFF;
      rec_count <= 17'h0;
      capacity <= 17'h0;
      fifo_ovf <= 1'b0;
      trig_seen <= 1'b0;
      stamp <= 32'h0;
    end else if (cfg_write) begin
      rec_state <= REC_OFF;
      trig_seen <= 1'b0;
    end else begin
      case (rec_state)
        REC_ARMED: begin
          if (trig_hit) begin
            rec_state <= REC_RUN;
            stamp <= timer;
            trig_seen <= 1'b1;
          end
        end
        REC_RUN: begin
          if (i_sample_tick) begin
            rec_count <= rec_count + 17'h1;
            if (rec_count + 17'h1 == capacity) rec_state <= REC_FULL;
          end
        end
        REC_FIFO: begin
          // A sample in the cycle of the take is the first of the next batch
          if (fifo_take) begin
            rec_count <= {16'h0, i_sample_tick};
            fifo_ovf <= 1'b0;
          end else if (i_sample_tick) begin
            if (rec_count == FIFO_DEPTH) begin
              rec_count <= 17'h1;
              fifo_ovf <= 1'b1;
            end else begin
              rec_count <= rec_count + 17'h1;
            end
          end
        end
        default: ;
      endcase
      if (start_go) begin
        rec_count <= 17'h0;
        fifo_ovf <= 1'b0;
        trig_seen <= 1'b0;
        capacity <= cap_max;
        if (op == OP_FIFO) rec_state <= REC_FIFO;
        else if (tcond == TRIG_MANUAL) begin
          rec_state <= REC_RUN;
          if ((count_in != 32'h0) & (cnt17 < cap_max))
            capacity <= cnt17;
        end else rec_state <= REC_ARMED;
      end
    end
  end

  // Job handling; result word and busy move only on calls or state changes
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      job_state <= JOB_IDLE;
      o_busy <= 1'b0;
      result <= RES_OK;
      count_out <= 32'h0;
      idx <= 17'h0;
      left <= 17'h0;
      grant <= 17'h0;
      done <= 17'h0;
      flags <= 3'h0;
      read_multi <= 1'b0;
      o_xfer <= '0;
    end else begin
      o_xfer.valid <= 1'b0;
      case (job_state)
        JOB_IDLE: begin
          if (call & ~req) result <= {14'h0, PH_IDLE};
          else if (call & (first_err != RES_OK)) begin
            result <= first_err;
          end else if (call & is_start) begin
            if (op == OP_FIFO & ~rec_active) result <= RES_OK;
            else begin
              job_state <= JOB_WAIT;
              o_busy <= 1'b1;
              result <= {STATE_RUN, 10'h0, PH_FIRST};
            end
          end else if (call & is_read) begin
            if (rec_state == REC_OFF) result <= RES_NOT_STARTED;
            else if (rec_active) begin
              job_state <= JOB_WAIT;
              o_busy <= 1'b1;
              result <= {STATE_RUN, 10'h0, PH_FIRST};
            end else begin
              job_state <= JOB_READ;
              o_busy <= 1'b1;
              result <= {STATE_RUN, 10'h0, PH_FIRST};
              idx <= rd_start;
              left <= rd_len;
              done <= 17'h0;
              flags <= rd_flags;
              read_multi <= job_mode[7:0] == MODE_READ_MULTI;
              grant <= (job_mode[7:0] == MODE_READ_MULTI) ?
                       READ_CHUNK : rd_len;
            end
          end
        end
        JOB_WAIT: begin
          result[BIT_WAIT_TRIG] <= rec_state == REC_ARMED;
          result[BIT_TRIGGERED] <= (rec_state == REC_RUN) & trig_seen;
          if (call & req) result[1:0] <= PH_SCOPE;
          if ((rec_state == REC_FULL) | (rec_state == REC_OFF) |
              (rec_state == REC_FIFO)) begin
            job_state <= JOB_IDLE;
            o_busy <= 1'b0;
            result <= RES_OK;
          end
        end
        JOB_READ: begin
          if (call & req) result[1:0] <= PH_NEXT;
          grant <= grant - {16'h0, xfer_go} +
                   ((call & req & read_multi) ? READ_CHUNK : 17'h0);
          if (left == 17'h0) begin
            job_state <= JOB_IDLE;
            o_busy <= 1'b0;
            count_out <= {15'h0, done};
            result <= (flags == 3'h0) ? RES_OK :
                      {STATE_ERR, flags, 9'h0};
          end else if (xfer_go) begin
            o_xfer.valid <= 1'b1;
            o_xfer.channel <= chan[2:0];
            o_xfer.index <= idx;
            idx <= idx + 17'h1;
            left <= left - 17'h1;
            done <= done + 17'h1;
          end
        end
        default: job_state <= JOB_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  sequence s_read_ends;
    (job_state == JOB_READ) && (left == 17'h0);
  endsequence

  sequence s_idle_reported;
    !o_busy && (result[15:12] != STATE_RUN);
  endsequence

  a_busy_running_code: assert property (
    o_busy |-> result[15:12] == STATE_RUN)
    else $error("busy without running code");
  a_read_end_count: assert property (
    s_read_ends |=> s_idle_reported ##0 (count_out[16:0] == $past(done)))
    else $error("read end count wrong");
  a_cfg_stops_rec: assert property (
    cfg_write |=> rec_state == REC_OFF)
    else $error("config write did not stop recording");
  a_scope_fills: assert property (
    (rec_state == REC_RUN && i_sample_tick && !cfg_write &&
     rec_count + 17'h1 == capacity) |=> rec_state == REC_FULL)
    else $error("scope did not finish at capacity");
  a_stamp_capture: assert property (
    (trig_hit && !cfg_write) |=> stamp == $past(timer))
    else $error("timestamp not captured");
  a_timer_rate: assert property (
    (timer != $past(timer)) |-> $past(us_div) == US_LAST)
    else $error("timer stepped off the microsecond");
  a_fifo_wrap_flag: assert property (
    (rec_state == REC_FIFO && i_sample_tick && !fifo_take &&
     !cfg_write && rec_count == FIFO_DEPTH)
    |=> fifo_ovf && rec_count == 17'h1)
    else $error("fifo wrap not flagged");
  a_start_ignored: assert property (
    (rec_active && call && req && is_start)
    |-> !start_go ##1 (o_busy && result[1:0] == PH_SCOPE))
    else $error("start accepted while recording");
  a_wb_ack_pulse: assert property (
    take |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack not a single pulse");
  a_not_started_idle: assert property (
    (job_state == JOB_IDLE && call && req && is_read &&
     first_err == RES_OK && rec_state == REC_OFF)
    |=> !o_busy && result == RES_NOT_STARTED)
    else $error("read before start not reported");
endmodule

// file: verification/capture_event_source.sv
// Purpose: acquisition side model feeding sample ticks, edges and faults
// Assumes: same clock as the job control block, events driven by NBA
// Notes: ticks are spaced one idle cycle apart so each is a clean pulse
`timescale 1ns/100ps
module capture_event_source (
  // Clock
  input wire logic i_ref_clk,
  // Acquisition events
  output logic o_sample_tick,
  output logic [7:0] o_rise,
  output logic [7:0] o_fall,
  output logic o_fault
);
  initial begin
    o_sample_tick = 1'b0;
    o_rise = 8'h00;
    o_fall = 8'h00;
    o_fault = 1'b0;
  end

  // One stored value per channel for each pulse
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_ref_clk) o_sample_tick <= 1'b1;
      @(posedge i_ref_clk) o_sample_tick <= 1'b0;
    end
  endtask

  // Level crossing on one channel, rising or falling
  task automatic edge_pulse(input int ch, input logic up);
    @(posedge i_ref_clk);
    if (up) begin
      o_rise[ch] <= 1'b1;
    end else begin
      o_fall[ch] <= 1'b1;
    end
    @(posedge i_ref_clk);
    o_rise <= 8'h00;
    o_fall <= 8'h00;
    repeat (2) @(posedge i_ref_clk);
  endtask

  task automatic set_fault(input logic f);
    @(posedge i_ref_clk) o_fault <= f;
  endtask
endmodule

// file: verification/capture_buffer_job_control_test.sv
// Purpose: self-checking bench for the capture job control block
// Assumes: classic Wishbone host, one job issued at a time
// Notes: scope runs use 8 channels so a full buffer is 8192 ticks
`timescale 1ns/100ps
module capture_buffer_job_control_test;
  import capture_job_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  wb_req_t wb = '0;
  logic [31:0] o_wb_dat;
  logic [31:0] q;
  logic [31:0] t0;
  logic [31:0] stamp;
  logic o_wb_ack;
  logic o_busy;
  logic tick;
  logic fault;
  logic [7:0] rise;
  logic [7:0] fall;
  xfer_t o_xfer;
  int bad_count = 0;
  int n_checks = 0;
  int xfers = 0;
  logic [2:0] want_ch = 3'h0;
  logic [3:0] bsel = 4'hF;
  logic [16:0] want_idx = 17'h0;

  initial begin
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  capture_buffer_job_control capture_buffer_job_control_inst (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_wb(wb),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_sample_tick(tick),
    .i_rise(rise), .i_fall(fall), .i_fault(fault), .o_busy(o_busy),
    .o_xfer(o_xfer));

  capture_event_source capture_event_source_inst (
    .i_ref_clk(i_ref_clk), .o_sample_tick(tick), .o_rise(rise),
    .o_fall(fall), .o_fault(fault));

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(posedge i_ref_clk) begin
    if (o_xfer.valid === 1'b1) begin
      xfers++;
      chk("xfer channel", {29'h0, o_xfer.channel}, {29'h0, want_ch});
      chk("xfer index", {15'h0, o_xfer.index}, {15'h0, want_idx});
      want_idx++;
    end
  end

  // Request held until ack is sampled; released at that same edge
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, dat: d, sel: bsel};
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    q = o_wb_dat;
    wb <= '0;
    if (n >= 50) chk("bus ack", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic call(input logic [7:0] mode);
    wr(OFS_MODE, {24'h0, mode});
    wr(OFS_CTRL, 32'h1);
    @(posedge i_ref_clk);
  endtask

  task automatic idle_wait;
    int n;
    n = 0;
    while (o_busy !== 1'b0 && n < 20000) begin
      @(posedge i_ref_clk);
      n++;
    end
    if (n >= 20000) chk("busy timeout", 32'h1, 32'h0);
  endtask

  task automatic res(input logic [15:0] exp);
    idle_wait();
    rd(OFS_RESULT);
    chk("result", q, {16'h0, exp});
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge i_ref_clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    rd(OFS_RESULT);
    chk("reset result", q, 32'h0);
    rd(8'h3C);
    chk("unmapped", q, 32'h0);
    wr(OFS_OFFSET, 32'h1234_5678);
    bsel = 4'h2;
    wr(OFS_OFFSET, 32'hAAAA_AAAA);
    bsel = 4'hF;
    rd(OFS_OFFSET);
    chk("byte lane", q, 32'h1234_AA78);
    wr(OFS_BASE, 32'h1000);
    call(MODE_READ_ONCE);
    res(RES_ADDR_RANGE);
    wr(OFS_BASE, 32'h0200);
    call(MODE_READ_ONCE);
    res(RES_NO_MODULE);
    wr(OFS_BASE, OWN_BASE);
    call(MODE_READ_ONCE);
    res(RES_NOT_CONFIGURED);
    wr(OFS_CFG, {30'h0, OP_FIFO});
    capture_event_source_inst.set_fault(1'b1);
    call(MODE_READ_ONCE);
    res(RES_INTERNAL);
    capture_event_source_inst.set_fault(1'b0);
    call(MODE_READ_ONCE);
    res(RES_NOT_STARTED);
    wr(OFS_CTRL, 32'h0);
    res(RES_OK);
    call(MODE_START);
    res(RES_OK);
    capture_event_source_inst.ticks(5);
    wr(OFS_CHAN, 32'h9);
    call(MODE_READ_ONCE);
    res(RES_BAD_CHANNEL);
    want_ch = 3'h3;
    wr(OFS_CHAN, 32'h3);
    wr(OFS_DEST, 32'd100);
    wr(OFS_OFFSET, 32'h2);
    wr(OFS_COUNT, 32'h1);
    xfers = 0;
    call(MODE_READ_ONCE);
    chk("busy", {31'h0, o_busy}, 32'h1);
    res(RES_OK);
    chk("fifo xfers", xfers, 32'd5);
    rd(OFS_COUNT);
    chk("count back", q, 32'd5);
    rd(OFS_STAMP);
    chk("fifo stamp", q, 32'h0);
    capture_event_source_inst.ticks(5);
    wr(OFS_DEST, 32'd3);
    want_idx = 17'h0;
    call(MODE_READ_ONCE);
    res(16'h8200);
    capture_event_source_inst.ticks(8191);
    wr(OFS_DEST, 32'd9000);
    want_idx = 17'h0;
    call(MODE_READ_ONCE);
    res(16'h8800);
    wr(OFS_CFG, 32'h0000_0231);
    call(MODE_START);
    rd(OFS_RESULT);
    chk("run nibble", {28'h0, q[15:12]}, {28'h0, STATE_RUN});
    chk("wait trig", {31'h0, q[BIT_WAIT_TRIG]}, 32'h1);
    call(MODE_START);
    rd(OFS_RESULT);
    chk("scope phase", {30'h0, q[1:0]}, {30'h0, PH_SCOPE});
    chk("busy armed", {31'h0, o_busy}, 32'h1);
    capture_event_source_inst.edge_pulse(1, 1'b1);
    capture_event_source_inst.edge_pulse(2, 1'b0);
    rd(OFS_RESULT);
    chk("still waiting", {31'h0, q[BIT_WAIT_TRIG]}, 32'h1);
    rd(OFS_TIMER);
    t0 = q;
    capture_event_source_inst.edge_pulse(2, 1'b1);
    rd(OFS_RESULT);
    chk("triggered", {30'h0, q[5:4]}, 32'h1);
    rd(OFS_STAMP);
    stamp = q;
    chk("stamp near", {31'h0, (stamp - t0) <= 32'd1}, 32'h1);
    capture_event_source_inst.ticks(8192);
    res(RES_OK);
    rd(OFS_STAMP);
    chk("stamp kept", q, stamp);
    want_ch = 3'h1;
    wr(OFS_CHAN, 32'h1);
    wr(OFS_OFFSET, 32'd8190);
    want_idx = 17'd8190;
    wr(OFS_COUNT, 32'd2);
    wr(OFS_DEST, 32'd100);
    xfers = 0;
    call(MODE_READ_ONCE);
    res(RES_OK);
    chk("scope xfers", xfers, 32'd2);
    rd(OFS_COUNT);
    chk("scope count", q, 32'd2);
    wr(OFS_COUNT, 32'd5);
    want_idx = 17'd8190;
    call(MODE_READ_ONCE);
    res(16'h8400);
    wr(OFS_OFFSET, 32'd9000);
    call(MODE_READ_ONCE);
    res(RES_BAD_OFFSET);
    wr(OFS_OFFSET, 32'h0);
    wr(OFS_COUNT, 32'd40);
    want_idx = 17'h0;
    xfers = 0;
    call(MODE_READ_MULTI);
    repeat (6) begin
      repeat (30) @(posedge i_ref_clk);
      if (o_busy === 1'b1) wr(OFS_CTRL, 32'h1);
    end
    res(RES_OK);
    chk("chunk xfers", xfers, 32'd40);
    wr(OFS_CFG, 32'h0000_0039);
    wr(OFS_COUNT, 32'd4);
    call(MODE_START);
    capture_event_source_inst.ticks(4);
    res(RES_OK);
    rd(OFS_STAMP);
    chk("manual stamp", q, 32'h0);
    wr(OFS_COUNT, 32'h0);
    want_idx = 17'h0;
    xfers = 0;
    call(MODE_READ_ONCE);
    res(RES_OK);
    chk("manual xfers", xfers, 32'd4);
    rd(OFS_COUNT);
    chk("manual count", q, 32'd4);
    wrap_up();
  end
endmodule
